/* core/rhsb_byte_lane.sv */
// Byte and word operand steering: lane select, merge and flags
`timescale 1ns/1ps
module rhsb_byte_lane import rhsb_pkg::*; (
	// Operation
	input wire logic i_byte_mode,
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_result,
	// Read side
	input wire logic [15:0] i_word_in,
	output logic [15:0] o_operand,
	// Write side
	output logic [1:0] o_lane,
	output logic [15:0] o_wdata,
	output rhsb_flags_t o_flags
);
	// Byte picked from the addressed half of a word
	wire logic odd = i_addr[0];
	wire logic [7:0] rd_byte = odd ? i_word_in[15:8] : i_word_in[7:0];
	assign o_operand = i_byte_mode ? {RHSB_ZERO8, rd_byte} : i_word_in;
	// Little endian lanes: even address low byte, odd address high byte
	assign o_lane = !i_byte_mode ? 2'h3 : (odd ? 2'h2 : 2'h1); // [RL18] [RL19]
	assign o_wdata = i_byte_mode ? {i_result[7:0], i_result[7:0]} : i_result;
	// Flags from the 8-bit or 16-bit result
	assign o_flags.n = i_byte_mode ? i_result[7] : i_result[15]; // [RL17]
	assign o_flags.z = i_byte_mode ? (i_result[7:0] == RHSB_ZERO8) : (i_result == RHSB_ZERO16); // [RL17]
	assign o_flags.c = 1'b0;
endmodule // rhsb_byte_lane

/* core/rhsb_core.sv */
// Read-after-write hazard stall control with byte mode operand handling
// Notes on behaviour
// [RL1] Detect address register RAW, stall one cycle
// [RL2] Compare executing destination with prefetched source register
// [RL3] Direct source never stalls
// [RL4] Direct destination, indirect source stalls
// [RL5] Plain indirect pair stalls only on self-map
// [RL6] Modified indirect destination, indirect source stalls
// [RL7] Each stall adds exactly one cycle
// [RL8] Stall kept even before exception entry
// [RL9] Calls write stack pointer; source use stalls
// [RL10] Jumps and returns never stall
// [RL11] Same checks inside loops and repeats
// [RL12] Stall after window access starts cycle two
// [RL13] Stall before window access in last cycle
// [RL14] Byte direct uses low byte, keeps high
// [RL15] Byte indirect accesses byte at pointer
// [RL16] Byte file operand accesses given byte
// [RL17] Byte flags follow eight-bit result
// [RL18] Byte addresses, little endian words
// [RL19] Odd byte store changes high byte only
// [RL20] Stack push post-increments, pop pre-decrements
// [RL21] Stall holds prefetch, PC, suppresses read
`timescale 1ns/1ps
module rhsb_core import rhsb_pkg::*; #(
	parameter int DW = RHSB_DW
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Pipeline inputs
	input wire rhsb_ins_t i_exec,
	input wire rhsb_ins_t i_pref,
	input wire logic i_exec_last,
	input wire logic i_exc_req,
	input wire logic i_loop_active,
	// Operation of the executing instruction
	input wire logic i_byte_mode,
	input wire logic i_wb_en,
	input wire logic [DW-1:0] i_result,
	input wire logic [3:0] i_rd_idx,
	input wire logic [DW-1:0] i_mem_rdata,
	input wire logic i_push,
	input wire logic i_pop,
	// Stall outputs
	output logic o_stall,
	output logic o_hold_pc,
	output logic o_rd_suppress,
	output logic o_exc_take,
	// Operand and write outputs
	output logic [DW-1:0] o_rd_data,
	output logic [DW-1:0] o_mem_operand,
	output rhsb_wr_t o_mem_wr,
	output rhsb_flags_t o_flags,
	output logic [DW-1:0] o_sp
);
	// ==========================================
	// Hazard decision
	typedef enum logic [1:0] {RHSB_ST_RUN, RHSB_ST_STALL, RHSB_ST_EXC} rhsb_state_t;
	rhsb_state_t state_reg, state_next;
	logic psv_seen_reg;
	logic exc_pend_reg;

	// Memory-mapped byte address of a working register
	function automatic logic [15:0] reg_map_addr(input logic [3:0] idx);
		reg_map_addr = RHSB_REG_MAP_BASE + 16'(idx) * RHSB_REG_MAP_STRIDE;
	endfunction

	// True when a mode reads through the register as a pointer
	function automatic logic is_ind(input rhsb_am_t m);
		is_ind = (m == RHSB_AM_IND) || (m == RHSB_AM_IND_MOD);
	endfunction

	// A direct source reads the register itself, so the write is in time
	// A pointer read comes too early after a direct write or a modified pointer
	// A plain pointer write clashes only on the pointer's own map slot
	// Jumps and returns write no working register and never stall
	// Destination register seen by the hazard check; calls target the stack pointer
	wire logic exec_writes = i_exec.valid && (i_exec.cls != RHSB_CL_JUMP) &&
		(i_exec.cls != RHSB_CL_RETURN) && (i_exec.cls != RHSB_CL_RETINT); // [RL10]
	wire logic is_call = i_exec.cls == RHSB_CL_CALL; // [RL9]
	wire rhsb_am_t dmode = is_call ? RHSB_AM_IND_MOD : i_exec.dst_mode; // [RL9] [RL20]
	wire logic [3:0] dreg = is_call ? RHSB_SP_IDX : i_exec.dst_reg; // [RL9]
	wire logic reg_match = exec_writes && i_pref.valid && (dreg == i_pref.src_reg); // [RL2]
	wire logic src_ind = is_ind(i_pref.src_mode); // [RL3]
	wire logic self_map = i_exec.dst_addr == reg_map_addr(dreg); // [RL5]
	wire logic rule_dir = (dmode == RHSB_AM_DIRECT) && src_ind; // [RL4]
	wire logic rule_ind = (dmode == RHSB_AM_IND) && src_ind && self_map; // [RL5]
	wire logic rule_mod = (dmode == RHSB_AM_IND_MOD) && src_ind; // [RL6]
	wire logic hazard = reg_match && (rule_dir || rule_ind || rule_mod); // [RL1]
	// Window accesses take two cycles; raise the stall on the access's second or the prior's last
	wire logic psv_exec = i_exec.cls == RHSB_CL_PSV;
	// Before a window access the prior instruction's last cycle decides
	wire logic stall_point = psv_exec ? psv_seen_reg : i_exec_last; // [RL12] [RL13]
	// Loops feed the same exec and prefetch pair, so no special case is needed
	wire logic start_stall = (state_reg == RHSB_ST_RUN) && hazard && stall_point; // [RL11]

	// Next state: one stall cycle, then any exception
	// A stall always runs its cycle before exception entry
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			RHSB_ST_RUN: begin
				if (start_stall) state_next = RHSB_ST_STALL; // [RL7]
				else if (i_exc_req) state_next = RHSB_ST_EXC;
			end
			RHSB_ST_STALL: begin
				state_next = (i_exc_req || exc_pend_reg) ? RHSB_ST_EXC : RHSB_ST_RUN; // [RL8]
			end
			RHSB_ST_EXC: state_next = RHSB_ST_RUN;
			default: state_next = RHSB_ST_RUN;
		endcase
	end

	// ==========================================
	// State and pending registers

	// Hazard state
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= RHSB_ST_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// First cycle of a window access; the flag marks its second
	wire logic psv_seen_next = psv_exec && !i_exec_last && !psv_seen_reg; // [RL12]
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			psv_seen_reg <= 1'b0;
		end else begin
			psv_seen_reg <= psv_seen_next;
		end
	end

	// Exception held back while its stall cycle runs
	wire logic exc_pend_next = (start_stall && i_exc_req) || (exc_pend_reg && (state_reg != RHSB_ST_STALL)); // [RL8]
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			exc_pend_reg <= 1'b0;
		end else begin
			exc_pend_reg <= exc_pend_next;
		end
	end

	// ==========================================
	// Stall outputs, each straight from a flip-flop
	wire logic exc_take_next = state_next == RHSB_ST_EXC;

	// One-cycle stall pulse
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_stall <= 1'b0;
		end else begin
			o_stall <= start_stall; // [RL7]
		end
	end

	// Program counter and prefetch held for the stall cycle
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_hold_pc <= 1'b0;
		end else begin
			o_hold_pc <= start_stall; // [RL21]
		end
	end

	// Operand read withheld for the stall cycle
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rd_suppress <= 1'b0;
		end else begin
			o_rd_suppress <= start_stall; // [RL21]
		end
	end

	// Exception entry, after any stall
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_exc_take <= 1'b0;
		end else begin
			o_exc_take <= exc_take_next; // [RL8]
		end
	end

	// ==========================================
	// Byte mode operand and write path
	// Both steering units share the result; they differ in byte address and read word
	// The register unit sees address zero, so it always picks the low byte
	logic [15:0] sp_reg;
	logic [15:0] rf_rd;
	logic [15:0] rf_operand;
	logic [15:0] mem_operand;
	logic [1:0] rf_lane;
	logic [1:0] mem_lane;
	logic [15:0] rf_wdata;
	logic [15:0] mem_wdata;
	rhsb_flags_t flags_c;
	// Flags of the memory unit are not reported
	rhsb_flags_t flags_unused;

	// Direct working register operand: low byte, high kept via lane
	rhsb_byte_lane u_rf_lane (
		.i_byte_mode(i_byte_mode),
		.i_addr(RHSB_ZERO16),
		.i_result(i_result),
		.i_word_in(rf_rd),
		.o_operand(rf_operand),
		.o_lane(rf_lane),
		.o_wdata(rf_wdata),
		.o_flags(flags_c)
	); // [RL14] [RL17]

	// Indirect and file operands: the byte at the byte address
	rhsb_byte_lane u_mem_lane (
		.i_byte_mode(i_byte_mode),
		.i_addr(i_exec.dst_addr),
		.i_result(i_result),
		.i_word_in(i_mem_rdata),
		.o_operand(mem_operand),
		.o_lane(mem_lane),
		.o_wdata(mem_wdata),
		.o_flags(flags_unused)
	); // [RL15] [RL16] [RL19]

	// Write enables, blocked during the stall cycle
	wire logic dst_direct = i_exec.dst_mode == RHSB_AM_DIRECT;
	wire logic dst_memory = is_ind(i_exec.dst_mode) || (i_exec.dst_mode == RHSB_AM_FILE); // [RL15] [RL16]
	wire logic rf_we = i_wb_en && dst_direct && (state_reg != RHSB_ST_STALL);
	wire logic mem_we = i_wb_en && dst_memory && (state_reg != RHSB_ST_STALL);
	// Byte address kept in byte mode, word aligned otherwise
	wire logic [15:0] mem_waddr = i_byte_mode ? i_exec.dst_addr : {i_exec.dst_addr[15:1], 1'b0}; // [RL18]

	// Working registers, written through byte lanes
	rhsb_regfile #(.DW(DW), .NREG(RHSB_NREG)) u_regfile (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_rd_idx(i_rd_idx),
		.o_rd_data(rf_rd),
		.i_wr_en(rf_we),
		.i_wr_idx(i_exec.dst_reg),
		.i_wr_lane(rf_lane),
		.i_wr_data(rf_wdata)
	); // [RL14]

	// ==========================================
	// Stack pointer and registered data outputs
	// Outputs update every cycle except where the stall cycle holds them; flags update only on a result write
	// The write request carries the byte address and the lanes it touches

	// Stack pointer: push and a finished call post-increment, pop pre-decrements
	wire logic call_push = is_call && i_exec.valid && i_exec_last; // [RL9]
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) sp_reg <= RHSB_SP_RESET;
		else if (i_push || call_push) sp_reg <= sp_reg + RHSB_WORD_STEP; // [RL20]
		else if (i_pop) sp_reg <= sp_reg - RHSB_WORD_STEP; // [RL20]
	end

	// Register operand, held while the stall cycle runs
	wire logic rd_take = state_next != RHSB_ST_STALL; // [RL21]
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rd_data <= RHSB_ZERO16;
		end else if (rd_take) begin
			o_rd_data <= rf_operand; // [RL14] [RL21]
		end
	end

	// Memory operand, held while the stall cycle runs
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_mem_operand <= RHSB_ZERO16;
		end else if (rd_take) begin
			o_mem_operand <= mem_operand; // [RL15] [RL16] [RL21]
		end
	end

	// Memory write request, lanes steered by the byte address
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_mem_wr <= '0;
		end else begin
			o_mem_wr <= '{en: mem_we, addr: mem_waddr, data: mem_wdata, lane: mem_lane}; // [RL19]
		end
	end

	// Status flags, refreshed on each result write
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_flags <= '0;
		end else if (i_wb_en) begin
			o_flags <= flags_c; // [RL17]
		end
	end

	// Stack pointer as seen outside
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_sp <= RHSB_SP_RESET;
		end else begin
			o_sp <= sp_reg;
		end
	end
endmodule // rhsb_core

/* core/rhsb_pkg.sv */
// Shared constants and carrier types for the hazard stall and byte operand unit
package rhsb_pkg;
	// ==========================================
	// Widths and fixed register numbers
	localparam int RHSB_DW = 16;
	localparam int RHSB_RW = 4;
	localparam int RHSB_NREG = 16;
	localparam logic [3:0] RHSB_SP_IDX = 4'h0f;
	localparam logic [15:0] RHSB_REG_MAP_STRIDE = 16'h0002;
	localparam logic [15:0] RHSB_REG_MAP_BASE = 16'h0000;
	localparam logic [15:0] RHSB_WORD_STEP = 16'h0002;
	localparam logic [15:0] RHSB_SP_RESET = 16'h0800;
	localparam logic [15:0] RHSB_ZERO16 = 16'h0000;
	localparam logic [7:0] RHSB_ZERO8 = 8'h00;

	// ==========================================
	// Addressing modes of one operand
	typedef enum logic [2:0] {
		RHSB_AM_NONE,
		RHSB_AM_DIRECT,
		RHSB_AM_IND,
		RHSB_AM_IND_MOD,
		RHSB_AM_FILE
	} rhsb_am_t;

	// Instruction classes that matter for hazards
	typedef enum logic [2:0] {
		RHSB_CL_PLAIN,
		RHSB_CL_CALL,
		RHSB_CL_JUMP,
		RHSB_CL_RETURN,
		RHSB_CL_RETINT,
		RHSB_CL_PSV
	} rhsb_cls_t;

	// Pre-decoded operand summary of one instruction
	typedef struct packed {
		logic valid;
		rhsb_cls_t cls;
		rhsb_am_t dst_mode;
		logic [3:0] dst_reg;
		rhsb_am_t src_mode;
		logic [3:0] src_reg;
		logic [15:0] dst_addr;
	} rhsb_ins_t;

	// Byte mode write request into data memory
	typedef struct packed {
		logic en;
		logic [15:0] addr;
		logic [15:0] data;
		logic [1:0] lane;
	} rhsb_wr_t;

	// Status flags from a result
	typedef struct packed {
		logic n;
		logic z;
		logic c;
	} rhsb_flags_t;
endpackage

/* core/rhsb_regfile.sv */
// Working register file with byte write lanes and a registered read port
`timescale 1ns/1ps
module rhsb_regfile import rhsb_pkg::*; #(
	parameter int DW = RHSB_DW,
	parameter int NREG = RHSB_NREG
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Read port
	input wire logic [3:0] i_rd_idx,
	output logic [DW-1:0] o_rd_data,
	// Write port with byte enables
	input wire logic i_wr_en,
	input wire logic [3:0] i_wr_idx,
	input wire logic [1:0] i_wr_lane,
	input wire logic [DW-1:0] i_wr_data
);
	logic [DW-1:0] mem_reg [NREG];

	// ==========================================
	// One row per register, byte lanes kept apart
	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : g_row
			always_ff @(posedge i_mclk or negedge i_rst_b) begin
				if (!i_rst_b) begin
					mem_reg[g] <= (g == int'(RHSB_SP_IDX)) ? RHSB_SP_RESET : RHSB_ZERO16;
				end else if (i_wr_en && i_wr_idx == 4'(g)) begin
					if (i_wr_lane[0]) mem_reg[g][7:0] <= i_wr_data[7:0];
					if (i_wr_lane[1]) mem_reg[g][15:8] <= i_wr_data[15:8];
				end
			end
		end
	endgenerate

	// Registered read data
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) o_rd_data <= RHSB_ZERO16;
		else o_rd_data <= mem_reg[i_rd_idx];
	end
endmodule // rhsb_regfile

/* test/rhsb_monitor.sv */
// Assertion checker for the hazard stall and byte operand unit
`timescale 1ns/1ps
module rhsb_monitor import rhsb_pkg::*; (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_b,
	// Watched inputs
	input wire rhsb_ins_t i_exec,
	input wire rhsb_ins_t i_pref,
	input wire logic i_exec_last,
	input wire logic i_exc_req,
	input wire logic i_byte_mode,
	input wire logic i_wb_en,
	input wire logic [15:0] i_result,
	input wire logic i_push,
	input wire logic i_pop,
	// Watched outputs
	input wire logic o_stall,
	input wire logic o_hold_pc,
	input wire logic o_rd_suppress,
	input wire logic o_exc_take,
	input wire rhsb_wr_t o_mem_wr,
	input wire rhsb_flags_t o_flags,
	input wire logic [15:0] o_sp
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	// ====
	// Reference hazard decode
	logic call, flow, srci, dsth, hz, go;
	assign call = i_exec.cls == RHSB_CL_CALL;
	assign flow = i_exec.cls inside {RHSB_CL_JUMP, RHSB_CL_RETURN, RHSB_CL_RETINT};
	assign srci = i_pref.src_mode inside {RHSB_AM_IND, RHSB_AM_IND_MOD};
	assign dsth = call ? (i_pref.src_reg == RHSB_SP_IDX) : (i_exec.dst_reg == i_pref.src_reg &&
		(i_exec.dst_mode inside {RHSB_AM_DIRECT, RHSB_AM_IND_MOD} ||
		(i_exec.dst_mode == RHSB_AM_IND && i_exec.dst_addr == {11'h000, i_exec.dst_reg, 1'h0})));
	assign hz = i_exec.valid && i_pref.valid && !flow && srci && dsth;
	assign go = hz && i_exec_last && !o_stall && i_exec.cls != RHSB_CL_PSV;
	// ====
	// Properties
	sequence s_one;
		o_stall ##1 !o_stall;
	endsequence
	property p_stall; go |=> s_one; endproperty
	a_stall: assert property (p_stall) else $error("stall missing or too long");
	property p_quiet; !hz |=> !o_stall; endproperty
	a_quiet: assert property (p_quiet) else $error("stall without hazard");
	property p_hold; o_hold_pc == o_stall && o_rd_suppress == o_stall; endproperty
	a_hold: assert property (p_hold) else $error("hold or suppress differs from stall");
	property p_exc; go && i_exc_req |=> o_stall && !o_exc_take ##1 o_exc_take; endproperty
	a_exc: assert property (p_exc) else $error("exception did not follow stall");
	property p_push; i_push && !i_pop && !o_stall && !call |=> ##1 o_sp == $past(o_sp) + RHSB_WORD_STEP; endproperty
	a_push: assert property (p_push) else $error("push did not step pointer up");
	property p_pop; i_pop && !i_push && !o_stall && !call |=> ##1 o_sp == $past(o_sp) - RHSB_WORD_STEP; endproperty
	a_pop: assert property (p_pop) else $error("pop did not step pointer down");
	property p_flags;
		i_wb_en && i_byte_mode && !o_stall |=> o_flags.z == (($past(i_result) & 16'h00ff) == RHSB_ZERO16) &&
			o_flags.n == (($past(i_result) & 16'h0080) != RHSB_ZERO16);
	endproperty
	a_flags: assert property (p_flags) else $error("byte flags wrong");
	property p_odd; o_mem_wr.en && o_mem_wr.addr[0] |-> o_mem_wr.lane == 2'h2; endproperty
	a_odd: assert property (p_odd) else $error("odd byte store lane wrong");
endmodule // rhsb_monitor

bind rhsb_core rhsb_monitor u_mon (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_exec(i_exec), .i_pref(i_pref),
	.i_exec_last(i_exec_last), .i_exc_req(i_exc_req), .i_byte_mode(i_byte_mode), .i_wb_en(i_wb_en),
	.i_result(i_result), .i_push(i_push), .i_pop(i_pop), .o_stall(o_stall), .o_hold_pc(o_hold_pc),
	.o_rd_suppress(o_rd_suppress), .o_exc_take(o_exc_take), .o_mem_wr(o_mem_wr), .o_flags(o_flags), .o_sp(o_sp));

/* test/testbench.sv */
// Self-checking bench for the hazard stall and byte operand unit
`timescale 1ns/1ps
module testbench import rhsb_pkg::*;;
	// ====
	// Stimulus and observed signals
	logic i_mclk, i_rst_b, i_exec_last, i_exc_req, i_loop_active, i_byte_mode, i_wb_en, i_push, i_pop;
	rhsb_ins_t i_exec, i_pref;
	logic [15:0] i_result, i_mem_rdata, o_rd_data, o_mem_operand, o_sp;
	logic [3:0] i_rd_idx;
	logic o_stall, o_hold_pc, o_rd_suppress, o_exc_take;
	rhsb_wr_t o_mem_wr;
	rhsb_flags_t o_flags;
	int mismatches, checks, cyc;
	rhsb_core uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_exec(i_exec), .i_pref(i_pref),
		.i_exec_last(i_exec_last), .i_exc_req(i_exc_req), .i_loop_active(i_loop_active),
		.i_byte_mode(i_byte_mode), .i_wb_en(i_wb_en), .i_result(i_result), .i_rd_idx(i_rd_idx),
		.i_mem_rdata(i_mem_rdata), .i_push(i_push), .i_pop(i_pop), .o_stall(o_stall), .o_hold_pc(o_hold_pc),
		.o_rd_suppress(o_rd_suppress), .o_exc_take(o_exc_take), .o_rd_data(o_rd_data),
		.o_mem_operand(o_mem_operand), .o_mem_wr(o_mem_wr), .o_flags(o_flags), .o_sp(o_sp));
	// Clock generator
	initial begin
		i_mclk = 1'h0;
		forever #10 i_mclk = ~i_mclk;
	end
	// Hang guard
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 2000) begin
			mismatches++;
			end_sim;
		end
	end
	// ====
	// Shared tasks
	task step;
		@(posedge i_mclk);
		#1;
	endtask
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// One instruction pair, then the stall and its end
	task hz(input rhsb_cls_t c, input rhsb_am_t dm, input logic [3:0] r, input logic [15:0] da,
		input rhsb_am_t sm, input logic e);
		i_exec = '{1'h1, c, dm, r, RHSB_AM_NONE, 4'h0, da};
		i_pref = '{1'h1, RHSB_CL_PLAIN, RHSB_AM_NONE, 4'h0, sm, r, RHSB_ZERO16};
		step;
		chk("stall", 16'(o_stall), 16'(e));
		i_exec.valid = 1'h0;
		i_pref.valid = 1'h0;
		step;
		chk("stall end", 16'(o_stall), RHSB_ZERO16);
	endtask
	// ====
	// Scenarios
	task t_sp;
		chk("sp reset", o_sp, RHSB_SP_RESET);
		i_push = 1'h1;
		step;
		i_push = 1'h0;
		step;
		chk("sp push", o_sp, RHSB_SP_RESET + RHSB_WORD_STEP);
		i_pop = 1'h1;
		step;
		i_pop = 1'h0;
		step;
		chk("sp pop", o_sp, RHSB_SP_RESET);
	endtask
	task t_table;
		hz(RHSB_CL_PLAIN, RHSB_AM_DIRECT, 4'h2, RHSB_ZERO16, RHSB_AM_DIRECT, 1'h0);
		hz(RHSB_CL_PLAIN, RHSB_AM_IND_MOD, 4'h2, RHSB_ZERO16, RHSB_AM_DIRECT, 1'h0);
		hz(RHSB_CL_PLAIN, RHSB_AM_DIRECT, 4'h2, RHSB_ZERO16, RHSB_AM_IND, 1'h1);
		hz(RHSB_CL_PLAIN, RHSB_AM_DIRECT, 4'h2, RHSB_ZERO16, RHSB_AM_IND_MOD, 1'h1);
		hz(RHSB_CL_PLAIN, RHSB_AM_IND, 4'h2, 16'h1000, RHSB_AM_IND, 1'h0);
		hz(RHSB_CL_PLAIN, RHSB_AM_IND, 4'h2, 16'h0004, RHSB_AM_IND_MOD, 1'h1);
		hz(RHSB_CL_PLAIN, RHSB_AM_IND_MOD, 4'h2, RHSB_ZERO16, RHSB_AM_IND, 1'h1);
		hz(RHSB_CL_PLAIN, RHSB_AM_IND_MOD, 4'h2, RHSB_ZERO16, RHSB_AM_IND_MOD, 1'h1);
	endtask
	task t_flow;
		hz(RHSB_CL_CALL, RHSB_AM_IND_MOD, RHSB_SP_IDX, RHSB_ZERO16, RHSB_AM_IND, 1'h1);
		hz(RHSB_CL_JUMP, RHSB_AM_DIRECT, 4'h2, RHSB_ZERO16, RHSB_AM_IND, 1'h0);
		hz(RHSB_CL_RETURN, RHSB_AM_DIRECT, 4'h2, RHSB_ZERO16, RHSB_AM_IND, 1'h0);
		hz(RHSB_CL_RETINT, RHSB_AM_DIRECT, 4'h2, RHSB_ZERO16, RHSB_AM_IND, 1'h0);
	endtask
	task t_loop;
		i_loop_active = 1'h1;
		hz(RHSB_CL_PLAIN, RHSB_AM_DIRECT, 4'h5, RHSB_ZERO16, RHSB_AM_IND, 1'h1);
		hz(RHSB_CL_PLAIN, RHSB_AM_DIRECT, 4'h5, RHSB_ZERO16, RHSB_AM_IND, 1'h1);
		i_loop_active = 1'h0;
	endtask
	task t_exc;
		i_exc_req = 1'h1;
		hz(RHSB_CL_PLAIN, RHSB_AM_DIRECT, 4'h3, RHSB_ZERO16, RHSB_AM_IND, 1'h1);
		chk("exc take", 16'(o_exc_take), 16'h0001);
		i_exc_req = 1'h0;
		step;
	endtask
	task t_psv;
		i_exec_last = 1'h0;
		i_exec = '{1'h1, RHSB_CL_PLAIN, RHSB_AM_DIRECT, 4'h6, RHSB_AM_NONE, 4'h0, RHSB_ZERO16};
		i_pref = '{1'h1, RHSB_CL_PSV, RHSB_AM_NONE, 4'h0, RHSB_AM_IND, 4'h6, RHSB_ZERO16};
		step;
		chk("before window early", 16'(o_stall), RHSB_ZERO16);
		i_exec_last = 1'h1;
		step;
		chk("before window last", 16'(o_stall), 16'h0001);
		i_exec_last = 1'h0;
		i_exec = '{1'h1, RHSB_CL_PSV, RHSB_AM_DIRECT, 4'h4, RHSB_AM_NONE, 4'h0, RHSB_ZERO16};
		i_pref = '{1'h1, RHSB_CL_PLAIN, RHSB_AM_NONE, 4'h0, RHSB_AM_IND, 4'h4, RHSB_ZERO16};
		step;
		chk("psv first", 16'(o_stall), RHSB_ZERO16);
		step;
		i_exec.valid = 1'h0;
		chk("psv second", 16'(o_stall), 16'h0001);
		i_exec_last = 1'h1;
		step;
	endtask
	task t_flags;
		i_byte_mode = 1'h1;
		i_wb_en = 1'h1;
		i_result = 16'h1200;
		step;
		chk("flags zero", 16'(o_flags), 16'h0002);
		i_result = 16'h0080;
		step;
		chk("flags neg", 16'(o_flags), 16'h0004);
		i_wb_en = 1'h0;
		i_byte_mode = 1'h0;
	endtask
	// Byte lanes on the register file and on data memory
	task t_byte;
		i_pref = '0;
		i_exec = '{1'h1, RHSB_CL_PLAIN, RHSB_AM_DIRECT, 4'h1, RHSB_AM_NONE, 4'h0, RHSB_ZERO16};
		i_rd_idx = 4'h1;
		i_wb_en = 1'h1;
		i_result = 16'h5555;
		step;
		i_byte_mode = 1'h1;
		i_result = 16'h0030;
		step;
		i_wb_en = 1'h0;
		i_byte_mode = 1'h0;
		repeat (2) step;
		chk("reg keeps high", o_rd_data, 16'h5530);
		i_byte_mode = 1'h1;
		step;
		chk("reg low byte", o_rd_data, 16'h0030);
		i_wb_en = 1'h1;
		i_result = 16'h0034;
		i_exec = '{1'h1, RHSB_CL_PLAIN, RHSB_AM_IND, 4'h1, RHSB_AM_NONE, 4'h0, 16'h1001};
		step;
		chk("odd en", 16'(o_mem_wr.en), 16'h0001);
		chk("odd lane", 16'(o_mem_wr.lane), 16'h0002);
		chk("odd byte", 16'(o_mem_wr.data[15:8]), 16'h0034);
		chk("odd addr", o_mem_wr.addr, 16'h1001);
		chk("odd read", o_mem_operand, 16'h0012);
		i_exec.dst_mode = RHSB_AM_FILE;
		i_exec.dst_addr = 16'h1000;
		step;
		chk("even lane", 16'(o_mem_wr.lane), 16'h0001);
		chk("even byte", 16'(o_mem_wr.data[7:0]), 16'h0034);
		chk("even read", o_mem_operand, 16'h0034);
		i_wb_en = 1'h0;
		i_byte_mode = 1'h0;
		i_exec.valid = 1'h0;
		step;
	endtask
	// Main sequence
	initial begin
		{i_rst_b, i_exc_req, i_loop_active, i_byte_mode, i_wb_en, i_push, i_pop} = 7'h00;
		i_exec_last = 1'h1;
		i_exec = '0;
		i_pref = '0;
		i_result = RHSB_ZERO16;
		i_mem_rdata = 16'h1234;
		i_rd_idx = 4'h0;
		repeat (8) @(posedge i_mclk);
		#1 i_rst_b = 1'h1;
		t_sp;
		t_table;
		t_flow;
		t_loop;
		t_exc;
		t_psv;
		t_flags;
		t_byte;
		end_sim;
	end
endmodule // testbench
